// ===== pkg/psfr_pkg.sv
// shared constants and types for the power and serial format register bank
// Summary of operation
// - writing one to bit 0 of the software reset register resets the device and the bit clears itself, while writing zero does nothing.
// - a software reset returns every register of the map to its power-on default.
// - the page register at address zero selects the page, and these registers answer only while page zero is selected.
// - the awake-select bit keeps the device asleep while zero, its reset value, and wakes it when one.
// - bit 7 of the sleep register picks an external analog rail at zero or the on-chip regulator at one.
// - the two-bit precharge field sets the reference quick-charge time to 3.5, 10, 50 or 100 ms.
// - with broadcast enabled the target address is fixed at 1001100, otherwise it comes from the address pins.
// - the power-down policy turns the core regulator off at once, after a timeout, or after a clean shutdown, and resets to the timeout policy.
// - the hold time field keeps the core regulator on for 30, 25, 10 or 5 ms after shutdown, resetting to 25 ms.
// - the frame format field at bits 7-6 picks TDM, I2S or left-justified framing, resetting to TDM.
// - the word length field at bits 5-4 picks 16, 20, 24 or 32 bits, resetting to 32 bits.
// - bit 3 inverts the frame sync and bit 2 inverts the bit clock relative to the standard protocol.
// - with the launch edge bit set, output data changes on the bit clock edge opposite to the default one.
// - in cycles without data the outputs drive zero when the idle fill bit is zero and float when it is one.
`default_nettype none
package psfr_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 21;
  // register offsets on page zero
  localparam logic [7:0] ADDR_PAGE  = 8'h00;
  localparam logic [7:0] ADDR_SOFT  = 8'h01;
  localparam logic [7:0] ADDR_SLEEP = 8'h02;
  localparam logic [7:0] ADDR_SHDN  = 8'h05;
  localparam logic [7:0] ADDR_SER   = 8'h07;
  localparam logic [7:0] PAGE_ZERO  = 8'h00;
  // reset values
  localparam logic [7:0] RST_PAGE  = 8'h00;
  localparam logic [7:0] RST_SLEEP = 8'h00;
  localparam logic [7:0] RST_SHDN  = 8'h05;
  localparam logic [7:0] RST_SER   = 8'h30;
  // writable bits; the rest are read-only zero
  localparam logic [7:0] MASK_SLEEP = 8'hFD;
  localparam logic [7:0] MASK_SHDN  = 8'h3F;
  localparam logic [7:0] MASK_SER   = 8'hFF;
  // field positions
  localparam int SOFT_BIT   = 0;
  localparam int AWAKE_BIT  = 0;
  localparam int BCAST_BIT  = 2;
  localparam int PRECHG_LSB = 3;
  localparam int RAIL_BIT   = 7;
  localparam int HOLD_LSB   = 0;
  localparam int POLICY_LSB = 2;
  localparam int FMT_LSB    = 6;
  localparam int WLEN_LSB   = 4;
  localparam int FSINV_BIT  = 3;
  localparam int BCINV_BIT  = 2;
  localparam int EDGE_BIT   = 1;
  localparam int FILL_BIT   = 0;
  // power-down policy codes
  localparam logic [1:0] POL_OFF_NOW = 2'h0;
  localparam logic [1:0] POL_CLEAN   = 2'h2;
  // addresses
  localparam logic [6:0] BCAST_ADDR    = 7'h4C;
  localparam logic [6:0] PIN_ADDR_BASE = 7'h20; // arbitrary value
  // timing
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned PRECHG_US_0 = 3500;
  localparam int unsigned PRECHG_US_1 = 10000;
  localparam int unsigned PRECHG_US_2 = 50000;
  localparam int unsigned PRECHG_US_3 = 100000;
  localparam int unsigned HOLD_US_0   = 30000;
  localparam int unsigned HOLD_US_1   = 25000;
  localparam int unsigned HOLD_US_2   = 10000;
  localparam int unsigned HOLD_US_3   = 5000;

  function automatic int unsigned us_to_cyc(input int unsigned us);
    us_to_cyc = us * (CLK_HZ / 1_000_000);
  endfunction

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_WAIT_DONE, ST_OFF} psfr_pd_state_t;
endpackage
`default_nettype wire

// ===== pkg/psfr_tmr_if.sv
// handshake between the control logic and a countdown timer
`timescale 1ns/1ps
`default_nettype none
interface psfr_tmr_if;
  logic                       start;
  logic                       abort;
  logic [psfr_pkg::CNT_W-1:0] load;
  logic                       busy;
  logic                       done;
  modport ctrl (output start, output abort, output load, input busy, input done);
  modport tmr  (input start, input abort, input load, output busy, output done);
endinterface
`default_nettype wire

// ===== design/psfr_timer.sv
// countdown timer used for reference precharge and regulator hold
`timescale 1ns/1ps
`default_nettype none
module psfr_timer
(
  input wire logic  clk,
  input wire logic  rst,
  psfr_tmr_if.tmr   t
);
  import psfr_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // abort wins over start so a reset never leaves a stale count behind
  always_comb
  begin
    cnt_d = cnt_q;
    if (t.abort)
      cnt_d = '0;
    else if (t.start)
      cnt_d = t.load;
    else if (cnt_q != '0)
      cnt_d = cnt_q - CNT_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign t.busy = (cnt_q != '0);
  assign t.done = (cnt_q == CNT_W'(1)) && !t.abort && !t.start;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tmr_load;
    (t.start && !t.abort) |=> (cnt_q == $past(t.load));
  endproperty
  a_tmr_load: assert property (p_tmr_load) else $error("timer did not load");

  property p_tmr_step;
    (t.busy && !t.start && !t.abort) |=> (cnt_q == $past(cnt_q) - CNT_W'(1));
  endproperty
  a_tmr_step: assert property (p_tmr_step) else $error("timer did not count");
endmodule // psfr_timer
`default_nettype wire

// ===== design/psfr_regs.sv
// page-zero power, shutdown and serial format registers with their control logic
`timescale 1ns/1ps
`default_nettype none
module psfr_regs #(
  parameter int unsigned PRECHG_CYC_0 = psfr_pkg::us_to_cyc(psfr_pkg::PRECHG_US_0),
  parameter int unsigned PRECHG_CYC_1 = psfr_pkg::us_to_cyc(psfr_pkg::PRECHG_US_1),
  parameter int unsigned PRECHG_CYC_2 = psfr_pkg::us_to_cyc(psfr_pkg::PRECHG_US_2),
  parameter int unsigned PRECHG_CYC_3 = psfr_pkg::us_to_cyc(psfr_pkg::PRECHG_US_3),
  parameter int unsigned HOLD_CYC_0   = psfr_pkg::us_to_cyc(psfr_pkg::HOLD_US_0),
  parameter int unsigned HOLD_CYC_1   = psfr_pkg::us_to_cyc(psfr_pkg::HOLD_US_1),
  parameter int unsigned HOLD_CYC_2   = psfr_pkg::us_to_cyc(psfr_pkg::HOLD_US_2),
  parameter int unsigned HOLD_CYC_3   = psfr_pkg::us_to_cyc(psfr_pkg::HOLD_US_3)
) (
  input  wire logic                        REF_CLK,
  input  wire logic                        RESET,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  input  wire logic [psfr_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [psfr_pkg::DATA_W-1:0] REG_WDATA,
  output var  logic [psfr_pkg::DATA_W-1:0] REG_RDATA,
  output var  logic                        REG_RVALID,
  output var  logic                        SOFT_RESET_ACTIVE,
  output var  logic                        SLEEP_ACTIVE,
  output var  logic                        ANALOG_RAIL_INTERNAL_EN,
  output var  logic                        PRECHARGE_ACTIVE,
  input  wire logic [1:0]                  ADDR_PINS,
  output var  logic [6:0]                  I2C_TARGET_ADDR,
  input  wire logic                        SHUTDOWN_PIN_N,
  input  wire logic                        SHUTDOWN_DONE,
  output var  logic                        CORE_REG_EN,
  output var  logic [1:0]                  FRAME_FORMAT,
  output var  logic [5:0]                  WORD_LEN_BITS,
  output var  logic                        FSYNC_INVERT,
  output var  logic                        BCLK_INVERT,
  input  wire logic                        BCLK_IN,
  input  wire logic [1:0]                  TX_DATA,
  input  wire logic                        TX_SLOT_ACTIVE,
  output var  logic [1:0]                  SDOUT,
  output var  logic [1:0]                  SDOUT_OEN
);
  import psfr_pkg::*;

  function automatic logic [CNT_W-1:0] pick_cyc(input logic [1:0] code, input int unsigned c0,
                                                input int unsigned c1, input int unsigned c2,
                                                input int unsigned c3);
    case (code)
      2'h0:    pick_cyc = CNT_W'(c0);
      2'h1:    pick_cyc = CNT_W'(c1);
      2'h2:    pick_cyc = CNT_W'(c2);
      default: pick_cyc = CNT_W'(c3);
    endcase
  endfunction

  function automatic logic [5:0] wlen_bits(input logic [1:0] code);
    case (code)
      2'h0:    wlen_bits = 6'h10;
      2'h1:    wlen_bits = 6'h14;
      2'h2:    wlen_bits = 6'h18;
      default: wlen_bits = 6'h20;
    endcase
  endfunction

  logic [7:0] page_q, page_d, sleep_q, sleep_d, shdn_q, shdn_d, ser_q, ser_d;
  logic [7:0] rdata_d;
  logic       soft_q, soft_d, rvalid_d;
  logic [5:0] wlen_d;
  logic       on_page0;

  // register bus: soft reset outranks any write in the same cycle; reads still return the current values
  always_comb
  begin
    on_page0 = (page_q == PAGE_ZERO);
    page_d   = page_q;
    sleep_d  = sleep_q;
    shdn_d   = shdn_q;
    ser_d    = ser_q;
    soft_d   = 1'b0;                                    // self clearing
    rdata_d  = 8'h00;
    rvalid_d = REG_RD;
    if (soft_q)
    begin
      page_d  = RST_PAGE;
      sleep_d = RST_SLEEP;
      shdn_d  = RST_SHDN;
      ser_d   = RST_SER;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == ADDR_PAGE)
        page_d = REG_WDATA;
      else if (on_page0)
      begin
        case (REG_ADDR)
          ADDR_SOFT:  soft_d  = REG_WDATA[SOFT_BIT];
          ADDR_SLEEP: sleep_d = REG_WDATA & MASK_SLEEP;
          ADDR_SHDN:  shdn_d  = REG_WDATA & MASK_SHDN;
          ADDR_SER:   ser_d   = REG_WDATA & MASK_SER;
          default:    ;
        endcase
      end
    end
    if (REG_RD)
    begin
      if (REG_ADDR == ADDR_PAGE)
        rdata_d = page_q;
      else if (on_page0)
      begin
        case (REG_ADDR)
          ADDR_SLEEP: rdata_d = sleep_q;
          ADDR_SHDN:  rdata_d = shdn_q;
          ADDR_SER:   rdata_d = ser_q;
          default:    rdata_d = 8'h00;                  // soft reset bit reads zero
        endcase
      end
    end
    wlen_d = wlen_bits(ser_d[WLEN_LSB +: 2]);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      page_q        <= RST_PAGE;
      sleep_q       <= RST_SLEEP;
      shdn_q        <= RST_SHDN;
      ser_q         <= RST_SER;
      soft_q        <= 1'b0;
      REG_RDATA     <= 8'h00;
      REG_RVALID    <= 1'b0;
      WORD_LEN_BITS <= 6'h20;
    end
    else
    begin
      page_q        <= page_d;
      sleep_q       <= sleep_d;
      shdn_q        <= shdn_d;
      ser_q         <= ser_d;
      soft_q        <= soft_d;
      REG_RDATA     <= rdata_d;
      REG_RVALID    <= rvalid_d;
      WORD_LEN_BITS <= wlen_d;
    end
  end

  // configuration bits straight from the register flops
  assign SOFT_RESET_ACTIVE       = soft_q;
  assign ANALOG_RAIL_INTERNAL_EN = sleep_q[RAIL_BIT];
  assign FRAME_FORMAT            = ser_q[FMT_LSB +: 2];
  assign FSYNC_INVERT            = ser_q[FSINV_BIT];
  assign BCLK_INVERT             = ser_q[BCINV_BIT];

  // pin synchronisers; stage one feeds stage two only
  logic [1:0] addr_s1_q, addr_s2_q;
  logic       shdn_s1_q, shdn_s2_q, bclk_s1_q, bclk_s2_q, bclk_s3_q;
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      addr_s1_q <= 2'h0;
      addr_s2_q <= 2'h0;
      shdn_s1_q <= 1'b1;
      shdn_s2_q <= 1'b1;
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
    end
    else
    begin
      addr_s1_q <= ADDR_PINS;
      addr_s2_q <= addr_s1_q;
      shdn_s1_q <= SHUTDOWN_PIN_N;
      shdn_s2_q <= shdn_s1_q;
      bclk_s1_q <= BCLK_IN;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
    end
  end

  // sleep, reference precharge and target address
  psfr_tmr_if pre_if ();
  psfr_tmr_if hold_if ();
  psfr_timer u_pre_tmr  (.clk(REF_CLK), .rst(RESET), .t(pre_if));
  psfr_timer u_hold_tmr (.clk(REF_CLK), .rst(RESET), .t(hold_if));

  logic       awake_dly_q, prechg_d, sleep_d_out;
  logic [6:0] addr_d;
  assign pre_if.start = sleep_q[AWAKE_BIT] && !awake_dly_q;
  assign pre_if.abort = !sleep_q[AWAKE_BIT] || soft_q;
  assign pre_if.load  = pick_cyc(sleep_q[PRECHG_LSB +: 2], PRECHG_CYC_0, PRECHG_CYC_1,
                                 PRECHG_CYC_2, PRECHG_CYC_3);
  always_comb
  begin
    sleep_d_out = !sleep_d[AWAKE_BIT];
    prechg_d    = PRECHARGE_ACTIVE;
    if (pre_if.abort)
      prechg_d = 1'b0;
    else if (pre_if.start)
      prechg_d = 1'b1;
    else if (pre_if.done)
      prechg_d = 1'b0;
    addr_d = sleep_q[BCAST_BIT] ? BCAST_ADDR : {PIN_ADDR_BASE[6:2], addr_s2_q};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      awake_dly_q      <= 1'b0;
      SLEEP_ACTIVE     <= 1'b1;
      PRECHARGE_ACTIVE <= 1'b0;
      I2C_TARGET_ADDR  <= {PIN_ADDR_BASE[6:2], 2'h0};
    end
    else
    begin
      awake_dly_q      <= sleep_q[AWAKE_BIT];
      SLEEP_ACTIVE     <= sleep_d_out;
      PRECHARGE_ACTIVE <= prechg_d;
      I2C_TARGET_ADDR  <= addr_d;
    end
  end

  // core regulator keep-alive after the shutdown pin asserts
  psfr_pd_state_t st_q, st_d;
  logic           shdn_on, core_d;
  logic [1:0]     policy;
  assign shdn_on       = !shdn_s2_q;
  assign policy        = shdn_q[POLICY_LSB +: 2];
  assign hold_if.start = (st_q == ST_RUN) && shdn_on && !soft_q &&
                         (policy != POL_OFF_NOW) && (policy != POL_CLEAN);
  assign hold_if.abort = !shdn_on || soft_q;
  assign hold_if.load  = pick_cyc(shdn_q[HOLD_LSB +: 2], HOLD_CYC_0, HOLD_CYC_1,
                                  HOLD_CYC_2, HOLD_CYC_3);
  always_comb
  begin
    st_d = st_q;
    if (soft_q || !shdn_on)
      st_d = ST_RUN;
    else
    begin
      case (st_q)
        ST_RUN:
        begin
          if (policy == POL_OFF_NOW)
            st_d = ST_OFF;
          else if (policy == POL_CLEAN)
            st_d = ST_WAIT_DONE;
          else
            st_d = ST_HOLD;        // reserved code behaves as the timeout policy
        end
        ST_HOLD:      if (hold_if.done) st_d = ST_OFF;
        ST_WAIT_DONE: if (SHUTDOWN_DONE) st_d = ST_OFF;
        ST_OFF:       st_d = ST_OFF;
        default:      st_d = ST_RUN;
      endcase
    end
    core_d = (st_d != ST_OFF);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      st_q        <= ST_RUN;
      CORE_REG_EN <= 1'b1;
    end
    else
    begin
      st_q        <= st_d;
      CORE_REG_EN <= core_d;
    end
  end

  // data pin stage; launch edge follows the clock polarity and the launch bit
  logic       launch;
  logic [1:0] sd_d, oen_d;
  assign launch = (ser_q[BCINV_BIT] ^ ser_q[EDGE_BIT]) ? (bclk_s2_q && !bclk_s3_q)
                                                       : (!bclk_s2_q && bclk_s3_q);
  always_comb
  begin
    sd_d  = SDOUT;
    oen_d = SDOUT_OEN;
    if (launch)
    begin
      sd_d  = TX_SLOT_ACTIVE ? TX_DATA : 2'h0;
      oen_d = TX_SLOT_ACTIVE ? 2'h0 : {2{ser_q[FILL_BIT]}};
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      SDOUT     <= 2'h0;
      SDOUT_OEN <= 2'h3;
    end
    else
    begin
      SDOUT     <= sd_d;
      SDOUT_OEN <= oen_d;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  property p_soft_clear;
    soft_q |=> !soft_q;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset stuck");
  property p_soft_defaults;
    soft_q |=> (page_q == RST_PAGE && sleep_q == RST_SLEEP && shdn_q == RST_SHDN
                && ser_q == RST_SER);
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("defaults lost");
  property p_page_gate;
    (REG_WR && !soft_q && page_q != PAGE_ZERO && REG_ADDR == ADDR_SER) |=> $stable(ser_q);
  endproperty
  a_page_gate: assert property (p_page_gate) else $error("write leaked off page");
  property p_sleep;
    SLEEP_ACTIVE == !sleep_q[AWAKE_BIT];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep output wrong");
  property p_prechg;
    $rose(sleep_q[AWAKE_BIT]) |=> PRECHARGE_ACTIVE;
  endproperty
  a_prechg: assert property (p_prechg) else $error("precharge not started");
  property p_bcast;
    sleep_q[BCAST_BIT] |=> (I2C_TARGET_ADDR == BCAST_ADDR);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast address wrong");
  property p_off_now;
    (st_q == ST_RUN && shdn_on && !soft_q && policy == POL_OFF_NOW) |=> !CORE_REG_EN;
  endproperty
  a_off_now: assert property (p_off_now) else $error("regulator not off");
  property p_wlen;
    (ser_q[WLEN_LSB +: 2] == 2'h0) |-> (WORD_LEN_BITS == 6'h10);
  endproperty
  a_wlen: assert property (p_wlen) else $error("word length wrong");
  property p_hold_edge;
    !launch |=> ($stable(SDOUT) && $stable(SDOUT_OEN));
  endproperty
  a_hold_edge: assert property (p_hold_edge) else $error("data moved off edge");
  property p_fill;
    (launch && !TX_SLOT_ACTIVE && ser_q[FILL_BIT]) |=> (SDOUT_OEN == 2'h3);
  endproperty
  a_fill: assert property (p_fill) else $error("idle fill not floating");
  property p_ro_zero;
    (REG_RD && page_q == PAGE_ZERO && REG_ADDR == ADDR_SHDN) |=> (REG_RDATA[7:6] == 2'h0);
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("reserved bits nonzero");

  c_hold_off: cover property (st_q == ST_HOLD ##1 st_q == ST_OFF);
  c_clean_off: cover property (st_q == ST_WAIT_DONE ##1 st_q == ST_OFF);
  c_prechg_end: cover property ($fell(PRECHARGE_ACTIVE));
  c_soft: cover property (soft_q);
endmodule // psfr_regs
`default_nettype wire

// ===== sim/psfr_host.sv
// host model that drives the page-relative register port of the bank
`timescale 1ns/1ps
`default_nettype none
module psfr_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output var  logic       wr,
  output var  logic       rd,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata
);
  // idle bus from time zero
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // one-cycle write strobe; signals held until the edge that takes it
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask

  // read strobe, then a bounded wait for the valid pulse
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = 8'hxx;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++)
      @(posedge clk) #1;
    if (rvalid === 1'b1)
      d = rdata;
  endtask
endmodule // psfr_host
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the power and serial format register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psfr_pkg::*;
  // short timer counts keep the run brief
  localparam int unsigned PC[4] = '{20, 30, 40, 50};
  localparam int unsigned HC[4] = '{60, 50, 40, 30};
  localparam int unsigned WL[4] = '{16, 20, 24, 32};
  logic       REF_CLK, RESET, REG_WR, REG_RD, REG_RVALID, SOFT_RESET_ACTIVE, SLEEP_ACTIVE;
  logic       ANALOG_RAIL_INTERNAL_EN, PRECHARGE_ACTIVE, SHUTDOWN_PIN_N, SHUTDOWN_DONE;
  logic       CORE_REG_EN, FSYNC_INVERT, BCLK_INVERT, BCLK_IN, TX_SLOT_ACTIVE;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
  logic [6:0] I2C_TARGET_ADDR;
  logic [5:0] WORD_LEN_BITS;
  logic [1:0] ADDR_PINS, FRAME_FORMAT, TX_DATA, SDOUT, SDOUT_OEN;
  int         err_count, tests_run, cyc, i, n, x;

  psfr_regs #(.PRECHG_CYC_0(PC[0]), .PRECHG_CYC_1(PC[1]), .PRECHG_CYC_2(PC[2]),
    .PRECHG_CYC_3(PC[3]), .HOLD_CYC_0(HC[0]), .HOLD_CYC_1(HC[1]), .HOLD_CYC_2(HC[2]),
    .HOLD_CYC_3(HC[3])) i_dut (.REF_CLK, .RESET, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .REG_RVALID, .SOFT_RESET_ACTIVE, .SLEEP_ACTIVE, .ANALOG_RAIL_INTERNAL_EN,
    .PRECHARGE_ACTIVE, .ADDR_PINS, .I2C_TARGET_ADDR, .SHUTDOWN_PIN_N, .SHUTDOWN_DONE,
    .CORE_REG_EN, .FRAME_FORMAT, .WORD_LEN_BITS, .FSYNC_INVERT, .BCLK_INVERT, .BCLK_IN,
    .TX_DATA, .TX_SLOT_ACTIVE, .SDOUT, .SDOUT_OEN);

  psfr_host i_host (.clk(REF_CLK), .rdata(REG_RDATA), .rvalid(REG_RVALID), .wr(REG_WR),
    .rd(REG_RD), .addr(REG_ADDR), .wdata(REG_WDATA));

  // 10 MHz clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  // hang guard: the sequence needs about 760 cycles
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      results();
    end
  end

  task automatic results;
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_host.rd8(a, d);
    chk(what, exp, d);
  endtask

  // one bit clock level change, then enough cycles for sync and launch
  task automatic bclk(input logic v);
    @(posedge REF_CLK);
    #1;
    BCLK_IN = v;
    repeat (6) @(posedge REF_CLK);
    #1;
  endtask

  initial
  begin
    RESET = 1'b1;
    ADDR_PINS = 2'h2;
    SHUTDOWN_PIN_N = 1'b1;
    SHUTDOWN_DONE = 1'b0;
    BCLK_IN = 1'b0;
    TX_DATA = 2'h0;
    TX_SLOT_ACTIVE = 1'b0;
    repeat (20) @(posedge REF_CLK);
    #1;
    RESET = 1'b0;
    // reset values and soft reset bit reading zero
    rdchk(ADDR_PAGE, RST_PAGE, "page");
    rdchk(ADDR_SOFT, 8'h00, "soft");
    rdchk(ADDR_SLEEP, RST_SLEEP, "sleep");
    rdchk(ADDR_SHDN, RST_SHDN, "shdn");
    rdchk(ADDR_SER, RST_SER, "ser");
    chk("asleep", 8'h01, {7'h0, SLEEP_ACTIVE});
    // every format, word length and polarity code
    for (i = 0; i < 4; i++)
    begin
      i_host.wr8(ADDR_SER, {i[1:0], i[1:0], i[1:0], 2'b00});
      chk("fmt", 8'(i), {6'h0, FRAME_FORMAT});
      chk("wlen", 8'(WL[i]), {2'h0, WORD_LEN_BITS});
      chk("inv", 8'(i), {6'h0, FSYNC_INVERT, BCLK_INVERT});
    end
    // zero to the reset bit does nothing; reserved bits stay zero
    i_host.wr8(ADDR_SOFT, 8'hFE);
    chk("swr0", 8'h00, {7'h0, SOFT_RESET_ACTIVE});
    rdchk(ADDR_SER, 8'hFC, "ser_kept");
    i_host.wr8(ADDR_SLEEP, 8'hFE);
    @(posedge REF_CLK);
    #1;
    rdchk(ADDR_SLEEP, 8'hFC, "sleep_ro");
    chk("rail1", 8'h01, {7'h0, ANALOG_RAIL_INTERNAL_EN});
    chk("bcast", {1'b0, BCAST_ADDR}, {1'b0, I2C_TARGET_ADDR});
    i_host.wr8(ADDR_SLEEP, 8'h00);
    @(posedge REF_CLK);
    #1;
    chk("rail0", 8'h00, {7'h0, ANALOG_RAIL_INTERNAL_EN});
    chk("pinad", {1'b0, PIN_ADDR_BASE[6:2], ADDR_PINS}, {1'b0, I2C_TARGET_ADDR});
    // pins move: two sync stages, then the address register
    ADDR_PINS = 2'h1;
    repeat (4) @(posedge REF_CLK);
    #1;
    chk("pinad1", {1'b0, PIN_ADDR_BASE[6:2], 2'h1}, {1'b0, I2C_TARGET_ADDR});
    i_host.wr8(ADDR_SHDN, 8'hFF);
    rdchk(ADDR_SHDN, 8'h3F, "shdn_ro");
    // page one hides the bank; page zero selected again before access
    i_host.wr8(ADDR_PAGE, 8'h01);
    i_host.wr8(ADDR_SER, 8'h00);
    rdchk(ADDR_SER, 8'h00, "pg1");
    chk("pg1fmt", 8'h03, {6'h0, FRAME_FORMAT});
    i_host.wr8(ADDR_PAGE, PAGE_ZERO);
    // wake with each precharge code and count the charge cycles
    for (i = 0; i < 4; i++)
    begin
      i_host.wr8(ADDR_SLEEP, {3'h0, i[1:0], 3'h1});
      chk("awake", 8'h00, {7'h0, SLEEP_ACTIVE});
      n = 0;
      repeat (PC[i] + 8)
      begin
        @(posedge REF_CLK);
        #1;
        n += (PRECHARGE_ACTIVE === 1'b1);
      end
      chk("prechg", 8'(PC[i]), 8'(n));
      i_host.wr8(ADDR_SLEEP, 8'h00);
    end
    // shutdown: timeout policy with all holds, then off-now and clean
    for (i = 0; i < 7; i++)
    begin
      x = (i == 4) ? 0 : (i == 5) ? 2 : (i == 6) ? 3 : 1;
      i_host.wr8(ADDR_SHDN, {4'h0, x[1:0], i[1:0]});
      SHUTDOWN_PIN_N = 1'b0;
      n = 0;
      while (CORE_REG_EN === 1'b1 && n < 200)
      begin
        @(posedge REF_CLK);
        #1;
        n++;
        SHUTDOWN_DONE = (x == 2 && n >= 100);
      end
      x = (x == 0) ? 4 : (x == 2) ? 102 : HC[i % 4] + 4;
      chk("regoff", 8'h01, {7'h0, n >= x - 2 && n <= x + 2});
      SHUTDOWN_PIN_N = 1'b1;
      SHUTDOWN_DONE = 1'b0;
      repeat (6) @(posedge REF_CLK);
      #1;
      chk("regon", 8'h01, {7'h0, CORE_REG_EN});
    end
    // launch edge and idle fill; non-launch edge must not move data
    for (i = 0; i < 2; i++)
    begin
      i_host.wr8(ADDR_SER, {6'h0, i[0], i[0]});
      TX_SLOT_ACTIVE = 1'b1;
      bclk(!i[0]);
      TX_DATA = 2'h1;
      bclk(i[0]);
      chk("sd1", 8'h01, {6'h0, SDOUT});
      chk("oen", 8'h00, {6'h0, SDOUT_OEN});
      TX_DATA = 2'h2;
      bclk(!i[0]);
      chk("hold", 8'h01, {6'h0, SDOUT});
      bclk(i[0]);
      chk("sd2", 8'h02, {6'h0, SDOUT});
      TX_SLOT_ACTIVE = 1'b0;
      bclk(!i[0]);
      bclk(i[0]);
      chk("fill", {6'h0, i[0], i[0]}, {6'h0, SDOUT_OEN});
      if (i == 0)
        chk("fill0", 8'h00, {6'h0, SDOUT});
    end
    // soft reset pulses, clears itself and restores defaults
    i_host.wr8(ADDR_SLEEP, 8'h80);
    i_host.wr8(ADDR_SOFT, 8'h01);
    chk("swr1", 8'h01, {7'h0, SOFT_RESET_ACTIVE});
    @(posedge REF_CLK);
    #1;
    chk("swrclr", 8'h00, {7'h0, SOFT_RESET_ACTIVE});
    chk("rail_def", 8'h00, {7'h0, ANALOG_RAIL_INTERNAL_EN});
    chk("wlen_def", 8'h20, {2'h0, WORD_LEN_BITS});
    rdchk(ADDR_SOFT, 8'h00, "soft_rb");
    rdchk(ADDR_SLEEP, RST_SLEEP, "sleep_def");
    rdchk(ADDR_SHDN, RST_SHDN, "shdn_def");
    rdchk(ADDR_SER, RST_SER, "ser_def");
    results();
  end
endmodule // tb
`default_nettype wire
